// ==== rtl/rfd_pkg.sv ====
// Purpose: constants, types and decode functions of the rf driver modulation setting bank
// Assumes: apb byte address is four times the register index
// Notes:   resistances are normalized values times 100
package rfd_pkg;
  localparam int         ADDR_W       = 12;
  localparam int         RES_W        = 13;
  localparam int         DEPTH_W      = 6;
  localparam logic [7:0] IDX_SPACE    = 8'h00;
  localparam logic [7:0] IDX_STATUS   = 8'h01;
  localparam logic [7:0] IDX_DRV      = 8'h28;
  localparam logic [7:0] IDX_TGT      = 8'h29;
  localparam logic [7:0] RST_TX_DRV   = 8'h70;
  localparam logic [7:0] RST_AUX      = 8'h10;
  localparam logic [7:0] RST_TGT      = 8'h70;
  localparam logic [7:0] AUX_WR_MASK  = 8'hf8;
  localparam int         AUX_REG_OFF  = 7;
  localparam int         AUX_EXT_POL  = 6;
  localparam int         AUX_EXT_EN   = 5;
  localparam int         AUX_DRV_LM   = 4;
  localparam int         AUX_RESISTIVE_AMPLITUDE_MOD_EN   = 3;
  localparam int         NIB_HI       = 4;
  localparam logic [3:0] CODE_HIZ     = 4'hf;
  localparam logic [RES_W-1:0] RES_ONE  = 13'h0064;
  localparam logic [RES_W-1:0] RES_TWO  = 13'h00c8;
  localparam logic [RES_W-1:0] RES_FOUR = 13'h0190;

  typedef enum logic [2:0] {
    RFD_SRC_DRIVER, RFD_SRC_TGT_MOD, RFD_SRC_TGT_UNMOD, RFD_SRC_RESISTIVE_AMPLITUDE_MOD_EN, RFD_SRC_HIZ
  } rfd_src_t;

  function automatic logic [DEPTH_W-1:0] rfd_depth(input logic [3:0] code);
    case (code)
      4'hb:    rfd_depth = 6'h11;
      4'hc:    rfd_depth = 6'h13;
      4'hd:    rfd_depth = 6'h16;
      4'he:    rfd_depth = 6'h1a;
      4'hf:    rfd_depth = 6'h28;
      default: rfd_depth = 6'h05 + {2'h0, code};
    endcase
  endfunction : rfd_depth

  // codes 0 and 1 are undefined, treated as the lowest resistance
  function automatic logic [RES_W-1:0] rfd_drv_res(input logic [3:0] code);
    if (code >= 4'h5)      rfd_drv_res = RES_FOUR;
    else if (code >= 4'h3) rfd_drv_res = RES_TWO;
    else                   rfd_drv_res = RES_ONE;
  endfunction : rfd_drv_res

  function automatic logic [RES_W-1:0] rfd_tgt_res(input logic [3:0] code);
    case (code)
      4'h0:    rfd_tgt_res = 13'h0019;
      4'h1:    rfd_tgt_res = 13'h0032;
      4'h2:    rfd_tgt_res = 13'h0064;
      4'h3:    rfd_tgt_res = 13'h00c8;
      4'h4:    rfd_tgt_res = 13'h0131;
      4'h5:    rfd_tgt_res = 13'h0190;
      4'h6:    rfd_tgt_res = 13'h0280;
      4'h7:    rfd_tgt_res = 13'h0320;
      4'h8:    rfd_tgt_res = 13'h0393;
      4'h9:    rfd_tgt_res = 13'h042c;
      4'ha:    rfd_tgt_res = 13'h0500;
      4'hb:    rfd_tgt_res = 13'h0640;
      4'hc:    rfd_tgt_res = 13'h0855;
      4'hd:    rfd_tgt_res = 13'h0c80;
      4'he:    rfd_tgt_res = 13'h1900;
      default: rfd_tgt_res = 13'h0000;
    endcase
  endfunction : rfd_tgt_res
endpackage : rfd_pkg

// ==== rtl/rfd_drive_sel.sv ====
// Purpose: picks the live driver resistance and modulation settings
// Assumes: all inputs are on the register clock
// Notes:   purely combinational, the caller registers the results
`timescale 1ns/1ps
module rfd_drive_sel (
  input  wire logic [7:0]                tx_drv,          // transmit driver setting
  input  wire logic [7:0]                aux,             // auxiliary modulation setting
  input  wire logic [7:0]                tgt,             // target modulation resistance
  input  wire logic                      tx_modulate,     // reader modulation envelope
  input  wire logic                      loadmod_data,    // target load modulation signal
  input  wire logic                      target_mode,     // passive target mode active
  output logic [rfd_pkg::RES_W-1:0]      res,             // resistance times 100
  output logic                           hiz,             // driver in high impedance
  output rfd_pkg::rfd_src_t              src,             // resistance source
  output logic [rfd_pkg::DEPTH_W-1:0]    depth,           // regulator am depth percent
  output logic                           reg_am_on,       // regulator am enabled
  output logic                           resistive_amplitude_mod_en_on        // resistive am switched in
);
  import rfd_pkg::*;

  logic [3:0] nib;

  always_comb begin
    nib       = tgt[NIB_HI-1:0];
    reg_am_on = ~aux[AUX_REG_OFF];
    depth     = reg_am_on ? rfd_depth(tx_drv[7:NIB_HI]) : '0;
    resistive_amplitude_mod_en_on = 1'b0;
    if (target_mode && aux[AUX_DRV_LM]) begin
      nib = loadmod_data ? tgt[7:NIB_HI] : tgt[NIB_HI-1:0];
      src = loadmod_data ? RFD_SRC_TGT_MOD : RFD_SRC_TGT_UNMOD;
      res = rfd_tgt_res(nib);
      hiz = (nib == CODE_HIZ);
    end else begin
      res = rfd_drv_res(tx_drv[NIB_HI-1:0]);
      hiz = (tx_drv[NIB_HI-1:0] == CODE_HIZ);
      src = RFD_SRC_DRIVER;
      if (!target_mode && tx_modulate && aux[AUX_RESISTIVE_AMPLITUDE_MOD_EN]) begin
        resistive_amplitude_mod_en_on = 1'b1;
        src       = RFD_SRC_RESISTIVE_AMPLITUDE_MOD_EN;
      end
    end
    // a floating driver cannot switch resistance, so resistive am drops too
    if (hiz) begin
      src       = RFD_SRC_HIZ;
      res       = '0;
      resistive_amplitude_mod_en_on = 1'b0;
    end
  end
endmodule : rfd_drive_sel

// ==== rtl/rfd_regs.sv ====
// Purpose: apb register bank for rf driver modulation settings
// Assumes: apb4 slave, zero wait states, modulation inputs on pclk
// Notes:   the space select bit chooses which bank answers at 28h
`timescale 1ns/1ps
module rfd_regs (
  input  wire logic                       pclk,                     // bus clock
  input  wire logic                       presetn,                  // async reset, low
  input  wire logic                       psel,                     // apb select
  input  wire logic                       penable,                  // apb enable
  input  wire logic                       pwrite,                   // apb direction
  input  wire logic [rfd_pkg::ADDR_W-1:0] paddr,                    // apb byte address
  input  wire logic [31:0]                pwdata,                   // apb write data
  input  wire logic [3:0]                 pstrb,                    // apb byte strobes
  output logic [31:0]                     prdata,                   // apb read data
  output logic                            pready,                   // apb ready
  output logic                            pslverr,                  // apb error
  input  wire logic                       tx_modulate,              // reader envelope
  input  wire logic                       loadmod_data,             // target load mod
  input  wire logic                       target_mode_active,       // passive target mode
  input  wire logic [6:0]                 resistive_mod_resistance, // resistive am code
  output logic [rfd_pkg::DEPTH_W-1:0]     amplitude_mod_depth,      // percent
  output logic                            regulator_am_en,          // regulator am on
  output logic                            resistive_am_active,      // resistive am now
  output logic [6:0]                      resistive_mod_code,       // resistive am code
  output logic [rfd_pkg::RES_W-1:0]       antenna_driver_output_res, // x100
  output logic                            antenna_driver_output_hiz, // high impedance
  output logic [2:0]                      driver_res_source,        // live source
  output logic                            external_loadmod_pin,     // pin level
  output logic                            external_loadmod_pin_oe_n // pin enable, low
);
  import rfd_pkg::*;

  typedef struct packed {
    logic                space_b;
    logic [7:0]          tx_drv;
    logic [7:0]          aux;
    logic [7:0]          tgt;
    logic [31:0]         rdata;
    logic                err;
    logic [DEPTH_W-1:0]  depth;
    logic                reg_am;
    logic                resistive_amplitude_mod_en;
    logic [6:0]          res_code;
    logic [RES_W-1:0]    res;
    logic                hiz;
    rfd_src_t            src;
    logic                ext_pin;
    logic                ext_oe_n;
  } rfd_state_t;

  localparam rfd_state_t RESET_STATE = '{
    space_b:  1'b0,
    tx_drv:   RST_TX_DRV,
    aux:      RST_AUX,
    tgt:      RST_TGT,
    rdata:    32'h0000_0000,
    err:      1'b0,
    depth:    '0,
    reg_am:   1'b0,
    resistive_amplitude_mod_en:   1'b0,
    res_code: 7'h00,
    res:      '0,
    hiz:      1'b0,
    src:      RFD_SRC_DRIVER,
    ext_pin:  1'b0,
    ext_oe_n: 1'b1
  };

  rfd_state_t              state;
  rfd_state_t              next_state;
  logic [RES_W-1:0]        sel_res;
  logic                    sel_hiz;
  rfd_src_t                sel_src;
  logic [DEPTH_W-1:0]      sel_depth;
  logic                    sel_reg_am;
  logic                    sel_resistive_amplitude_mod_en;
  logic                    setup;
  logic                    access;
  logic [7:0]              idx;
  logic                    aligned;
  logic                    lane0;

  rfd_drive_sel u_sel (
    .tx_drv      (state.tx_drv),
    .aux         (state.aux),
    .tgt         (state.tgt),
    .tx_modulate (tx_modulate),
    .loadmod_data(loadmod_data),
    .target_mode (target_mode_active),
    .res         (sel_res),
    .hiz         (sel_hiz),
    .src         (sel_src),
    .depth       (sel_depth),
    .reg_am_on   (sel_reg_am),
    .resistive_amplitude_mod_en_on   (sel_resistive_amplitude_mod_en)
  );

  // index decode; word address bits above the index must be zero
  function automatic logic mapped(input logic [7:0] i, input logic sp_b);
    mapped = (i == IDX_SPACE) || (i == IDX_STATUS) || (i == IDX_DRV) ||
             ((i == IDX_TGT) && !sp_b);
  endfunction : mapped

  function automatic logic [31:0] read_word(input rfd_state_t s, input logic [7:0] i);
    read_word = 32'h0000_0000;
    case (i)
      IDX_SPACE:  read_word[0] = s.space_b;
      IDX_STATUS: read_word    = {14'h0000, s.resistive_amplitude_mod_en, s.reg_am, s.depth,
                                  4'h0, s.hiz, s.ext_pin, s.ext_oe_n, s.src};
      IDX_DRV:    read_word[7:0] = s.space_b ? (s.aux & AUX_WR_MASK)
                                             : s.tx_drv;
      IDX_TGT:    read_word[7:0] = s.tgt;
      default:    read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  always_comb begin
    next_state = state;
    setup      = psel && !penable;
    access     = psel && penable;
    idx        = paddr[9:2];
    aligned    = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
    lane0      = pstrb[0];

    // read data and error are caught in the setup cycle so they leave flops
    if (setup) begin
      next_state.err   = !(aligned && mapped(idx, state.space_b));
      // refused reads return zero, even where the index decodes in the other space
      next_state.rdata = (!pwrite && !next_state.err) ? read_word(state, idx)
                                                      : 32'h0000_0000;
    end

    // writes land only on the access edge, lane 0 carries every field
    if (access && pwrite && !state.err && lane0) begin
      case (idx)
        IDX_SPACE: next_state.space_b = pwdata[0];
        IDX_DRV: begin
          if (state.space_b)
            next_state.aux = pwdata[7:0] & AUX_WR_MASK;
          else
            next_state.tx_drv = pwdata[7:0];
        end
        // the host must load both nibbles before entering target mode
        IDX_TGT: next_state.tgt = pwdata[7:0];
        default: next_state.space_b = state.space_b;
      endcase
    end

    next_state.depth    = sel_depth;
    next_state.reg_am   = sel_reg_am;
    next_state.resistive_amplitude_mod_en   = sel_resistive_amplitude_mod_en;
    next_state.res_code = sel_resistive_amplitude_mod_en ? resistive_mod_resistance : 7'h00;
    next_state.res      = sel_res;
    next_state.hiz      = sel_hiz;
    next_state.src      = sel_src;

    // disabled pin floats, so the level is parked low
    if (state.aux[AUX_EXT_EN]) begin
      next_state.ext_pin  = loadmod_data ^ state.aux[AUX_EXT_POL];
      next_state.ext_oe_n = 1'b0;
    end else begin
      next_state.ext_pin  = 1'b0;
      next_state.ext_oe_n = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  assign prdata                    = state.rdata;
  assign pready                    = psel && penable;
  assign pslverr                   = psel && penable && state.err;
  assign amplitude_mod_depth       = state.depth;
  assign regulator_am_en           = state.reg_am;
  assign resistive_am_active       = state.resistive_amplitude_mod_en;
  assign resistive_mod_code        = state.res_code;
  assign antenna_driver_output_res = state.res;
  assign antenna_driver_output_hiz = state.hiz;
  assign driver_res_source         = state.src;
  assign external_loadmod_pin      = state.ext_pin;
  assign external_loadmod_pin_oe_n = state.ext_oe_n;
endmodule : rfd_regs

// ==== bench/rfd_chk.sv ====
// Purpose: port level checks of the rf driver modulation bank
// Assumes: single pclk domain, presetn async active low
// Notes:   bound into rfd_regs after the module
`timescale 1ns/1ps
module rfd_chk (
  input wire logic                        pclk,                      // clock
  input wire logic                        presetn,                   // reset, low
  input wire logic                        psel,                      // select
  input wire logic                        penable,                   // enable
  input wire logic                        pwrite,                    // direction
  input wire logic [31:0]                 prdata,                    // read data
  input wire logic                        pready,                    // ready
  input wire logic                        loadmod_data,              // load mod in
  input wire logic                        target_mode_active,        // target mode
  input wire logic [6:0]                  resistive_mod_resistance,  // am code in
  input wire logic [rfd_pkg::DEPTH_W-1:0] amplitude_mod_depth,       // percent
  input wire logic                        regulator_am_en,           // regulator am
  input wire logic                        resistive_am_active,       // resistive am
  input wire logic [6:0]                  resistive_mod_code,        // am code out
  input wire logic [rfd_pkg::RES_W-1:0]   antenna_driver_output_res, // x100
  input wire logic                        antenna_driver_output_hiz, // high z
  input wire logic [2:0]                  driver_res_source,         // source
  input wire logic                        external_loadmod_pin,      // pin
  input wire logic                        external_loadmod_pin_oe_n  // pin enable
);
  import rfd_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_access: assert property (pready == (psel && penable))
    else $error("ready not tied to access phase");
  a_read_holds: assert property (psel && penable && pready |=> $stable(prdata))
    else $error("read data moved after access");
  a_depth_table: assert property (regulator_am_en |-> amplitude_mod_depth inside
    {[6'h05:6'h0f], 6'h11, 6'h13, 6'h16, 6'h1a, 6'h28}) else $error("depth off table");
  a_depth_off: assert property (!regulator_am_en |-> amplitude_mod_depth == 6'h00)
    else $error("depth while regulator am off");
  a_hiz_forces: assert property (antenna_driver_output_hiz |->
    antenna_driver_output_res == '0 && driver_res_source == 3'h4 && !resistive_am_active)
    else $error("high z not consistent");
  a_pin_idle: assert property (external_loadmod_pin_oe_n |-> !external_loadmod_pin)
    else $error("pin active while disabled");
  a_pin_follows: assert property ($changed(loadmod_data) && !external_loadmod_pin_oe_n
    && !$past(psel && penable && pwrite) |=> $changed(external_loadmod_pin))
    else $error("pin missed load mod change");
  a_resam_code: assert property (resistive_mod_code ==
    (resistive_am_active ? $past(resistive_mod_resistance) : 7'h00))
    else $error("resistive am code wrong");
  a_mod_source: assert property (driver_res_source == 3'h1 |->
    $past(loadmod_data) && $past(target_mode_active)) else $error("modulated source wrong");
  a_unmod_source: assert property (driver_res_source == 3'h2 |->
    !$past(loadmod_data) && $past(target_mode_active)) else $error("unmodulated source wrong");
endmodule : rfd_chk

bind rfd_regs rfd_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
  .loadmod_data, .target_mode_active, .resistive_mod_resistance, .amplitude_mod_depth,
  .regulator_am_en, .resistive_am_active, .resistive_mod_code, .antenna_driver_output_res,
  .antenna_driver_output_hiz, .driver_res_source, .external_loadmod_pin,
  .external_loadmod_pin_oe_n);

// ==== bench/testbench.sv ====
// Purpose: directed bench of the rf driver modulation bank
// Assumes: zero wait apb slave, outputs lag one pclk edge
// Notes:   no partner, bench drives the modulation inputs
`timescale 1ns/1ps
module testbench;
  import rfd_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic              tx_mod, ld, tgt_mode, ram_on, hiz, pin, oe_n, reg_on;
  logic [6:0]        ram_in, ram_code;
  logic [DEPTH_W-1:0] depth;
  logic [RES_W-1:0]  res;
  logic [2:0]        src;
  int                errors, samples_checked, cyc;
  localparam logic [5:0] DEP [16] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b,
    6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h11, 6'h13, 6'h16, 6'h1a, 6'h28};

  rfd_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .tx_modulate(tx_mod), .loadmod_data(ld), .target_mode_active(tgt_mode),
    .resistive_mod_resistance(ram_in), .amplitude_mod_depth(depth), .regulator_am_en(reg_on),
    .resistive_am_active(ram_on), .resistive_mod_code(ram_code), .antenna_driver_output_res(res),
    .antenna_driver_output_hiz(hiz), .driver_res_source(src), .external_loadmod_pin(pin),
    .external_loadmod_pin_oe_n(oe_n));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held from setup until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= {4{w}};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask : settle

  task automatic t_reset;
    apb(1'b0, 12'h0a0, 32'h0);
    chk(rd, 32'h70);
    apb(1'b0, 12'h0a4, 32'h0);
    chk(rd, 32'h70);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h0a0, 32'h0);
    chk(rd, 32'h10);
    chk(32'(depth), 32'h0c);
    chk(32'(reg_on), 32'h1);
    chk(32'(oe_n), 32'h1);
    apb(1'b0, 12'h0a4, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
  endtask : t_reset

  task automatic t_drv;
    logic [12:0] e;
    apb(1'b1, 12'h000, 32'h0);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 12'h0a0, 32'(c * 17));
      settle();
      e = (c == 15) ? 13'h0 : (c >= 5) ? 13'h190 : (c >= 3) ? 13'h0c8 : 13'h064;
      chk(32'(depth), 32'(DEP[c]));
      chk(32'(res), 32'(e));
      chk(32'(hiz), 32'(c == 15));
    end
    apb(1'b1, 12'h0a0, 32'h72);
  endtask : t_drv

  task automatic t_aux;
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h0a0, 32'hff);
    apb(1'b0, 12'h0a0, 32'h0);
    chk(rd, 32'hf8);
    settle();
    chk(32'(reg_on), 32'h0);
    chk(32'(depth), 32'h0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h0a0, k[1] ? 32'h60 : 32'h20);
      ld <= k[0];
      settle();
      chk(32'(pin), 32'(k[0] ^ k[1]));
      chk(32'(oe_n), 32'h0);
    end
    apb(1'b1, 12'h0a0, 32'h10);
    settle();
    chk(32'(oe_n), 32'h1);
  endtask : t_aux

  task automatic t_tgt;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h0a4, 32'hd3);
    tgt_mode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      ld <= k[0];
      settle();
      chk(32'(res), k ? 32'h0c80 : 32'h00c8);
      chk(32'(src), k ? 32'h1 : 32'h2);
    end
    apb(1'b1, 12'h0a4, 32'hf0);
    settle();
    chk(32'(hiz), 32'h1);
    tgt_mode <= 1'b0;
    ld <= 1'b0;
  endtask : t_tgt

  task automatic t_ram;
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h0a0, 32'h18);
    tx_mod <= 1'b1;
    ram_in <= 7'h45;
    settle();
    chk(32'(ram_on), 32'h1);
    chk(32'(ram_code), 32'h45);
    chk(32'(src), 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0003_300b);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h0a0, 32'h7f);
    settle();
    chk(32'(ram_on), 32'h0);
    chk(32'(ram_code), 32'h0);
    chk(32'(src), 32'h4);
    apb(1'b1, 12'h0a0, 32'h72);
    apb(1'b1, 12'h000, 32'h1);
    settle();
    chk(32'(ram_on), 32'h1);
    apb(1'b1, 12'h0a0, 32'h10);
    settle();
    chk(32'(ram_on), 32'h0);
  endtask : t_ram

  initial begin
    {presetn, psel, penable, pwrite, tx_mod, ld, tgt_mode} = '0;
    {paddr, pwdata, pstrb, ram_in, rd, er} = '0;
    {errors, samples_checked, cyc} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_drv();
    t_aux();
    t_tgt();
    t_ram();
    end_of_test();
  end
endmodule : testbench
